// ---- rtl/serial_channel.v ----
// asynchronous serial channel with multi-processor framing, registers and transmit fifo
`timescale 1ns/1ps
`default_nettype none
`include "serial_channel_defines.vh"

module serial_channel (
    input wire clk,
    input wire arst_n,
    input wire ce,
    input wire [15:0] bus_addr,
    input wire bus_wr,
    input wire bus_rd,
    input wire [7:0] bus_wdata,
    output wire [7:0] bus_rdata,
    input wire [2:0] prescale_select,
    input wire ext_clk_in,
    input wire multiproc_mode,
    input wire mp_append_bit,
    input wire [7:0] tx_data,
    input wire tx_valid,
    output wire tx_ready,
    output wire [7:0] rx_data,
    output wire rx_data_valid,
    input wire rx_read,
    input wire serial_in_pin,
    output wire serial_out_pin,
    output wire rx_complete_irq,
    output wire rx_error_irq
);

    // frame field states shared by both directions, except S_STOP2 which only the transmitter uses
    localparam [2:0] S_IDLE = 3'd0;
    localparam [2:0] S_START = 3'd1;
    localparam [2:0] S_DATA = 3'd2;
    localparam [2:0] S_MP = 3'd3;
    localparam [2:0] S_PAR = 3'd4;
    localparam [2:0] S_STOP1 = 3'd5;
    localparam [2:0] S_STOP2 = 3'd6;
    localparam [7:0] RX_STATUS_RST = `RST_RECEIVE_ERROR_STATUS;

    // ==========================================================
    // functions
    function [2:0] next_field;
        input [2:0] cur;
        input mp_on;
        input [1:0] par;
        begin
            if (cur == S_DATA && mp_on) begin
                next_field = S_MP;
            end else if (par != `PARITY_NONE) begin
                next_field = S_PAR;
            end else begin
                next_field = S_STOP1;
            end
        end
    endfunction

    function parity_bit;
        input acc;
        input [1:0] par;
        begin
            case (par)
                `PARITY_ODD: parity_bit = ~acc;
                `PARITY_EVEN: parity_bit = acc;
                default: parity_bit = 1'b0;
            endcase
        end
    endfunction

    // ==========================================================
    // registers
    reg [7:0] mode_reg;
    reg [7:0] divisor_reg;
    reg [7:0] rdata_reg;
    reg buffer_full_reg;
    reg shift_busy_reg;
    reg [3:0] rx_status_reg;

    wire power_on = mode_reg[`BIT_CLOCK_POWER_ENABLE];
    wire tx_en = mode_reg[`BIT_TRANSMIT_ENABLE] & power_on;
    wire rx_en = mode_reg[`BIT_RECEIVE_ENABLE] & power_on;
    wire [1:0] par_mode = mode_reg[`BIT_PARITY_SELECT_HIGH:`BIT_PARITY_SELECT_LOW];
    wire char8 = mode_reg[`BIT_CHAR_LENGTH_SELECT];
    wire two_stops = mode_reg[`BIT_STOP_BIT_COUNT_SELECT];
    wire err_route = mode_reg[`BIT_ERROR_IRQ_ROUTING];
    wire [2:0] last_bit = char8 ? 3'd7 : 3'd6;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_reg <= `RST_SERIAL_MODE_CONTROL;
            divisor_reg <= `RST_BAUD_DIVISOR;
        end else if (ce && bus_wr) begin
            if (bus_addr == `ADDR_SERIAL_MODE_CONTROL) begin
                mode_reg <= bus_wdata;
            end
            if (bus_addr == `ADDR_BAUD_DIVISOR) begin
                divisor_reg <= bus_wdata;
            end
        end
    end

    // read data held until the next read; unmapped reads return zero
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_reg <= 8'h00;
        end else if (ce && bus_rd) begin
            case (bus_addr)
                `ADDR_SERIAL_MODE_CONTROL: rdata_reg <= mode_reg;
                `ADDR_BAUD_DIVISOR: rdata_reg <= divisor_reg;
                `ADDR_TRANSMIT_STATUS: rdata_reg <= {6'h00, buffer_full_reg, shift_busy_reg};
                `ADDR_RECEIVE_ERROR_STATUS: rdata_reg <= {4'h0, rx_status_reg};
                default: rdata_reg <= 8'h00;
            endcase
        end
    end
    assign bus_rdata = rdata_reg;

    // ==========================================================
    // prescaler and baud divider
    reg [7:0] presc_reg;
    reg ext_prev_reg;
    reg [7:0] brg_cnt_reg;
    wire [7:0] presc_mask = (8'h01 << prescale_select) - 8'h01;
    wire src_tick = power_on && ((prescale_select == 3'd0) ? (ext_clk_in & ~ext_prev_reg)
        : ((presc_reg & presc_mask) == presc_mask));
    // prohibited small divisors run as the smallest legal one
    wire [7:0] k_eff = (divisor_reg[7:3] == 5'h00) ? `MIN_DIVISOR : divisor_reg;
    wire baud_tick = src_tick && (brg_cnt_reg == k_eff - 8'h01);

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            presc_reg <= 8'h00;
            ext_prev_reg <= 1'b0;
            brg_cnt_reg <= 8'h00;
        end else if (ce) begin
            ext_prev_reg <= ext_clk_in;
            if (!power_on) begin
                presc_reg <= 8'h00;
                brg_cnt_reg <= 8'h00;
            end else begin
                presc_reg <= presc_reg + 8'h01;
                if (baud_tick) begin
                    brg_cnt_reg <= 8'h00;
                end else if (src_tick) begin
                    brg_cnt_reg <= brg_cnt_reg + 8'h01;
                end
            end
        end
    end

    // ==========================================================
    // enable settling, counted in prescaler ticks
    reg [1:0] tx_settle_reg;
    reg [1:0] rx_settle_reg;
    wire tx_go = tx_en && (tx_settle_reg == `SETTLE_TICKS);
    wire rx_go = rx_en && (rx_settle_reg == `SETTLE_TICKS);

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_settle_reg <= 2'h0;
            rx_settle_reg <= 2'h0;
        end else if (ce) begin
            if (!tx_en) begin
                tx_settle_reg <= 2'h0;
            end else if (src_tick && !tx_go) begin
                tx_settle_reg <= tx_settle_reg + 2'h1;
            end
            if (!rx_en) begin
                rx_settle_reg <= 2'h0;
            end else if (src_tick && !rx_go) begin
                rx_settle_reg <= rx_settle_reg + 2'h1;
            end
        end
    end

    // ==========================================================
    // transmit buffer fed from the fifo
    wire fifo_valid;
    wire [7:0] fifo_data;
    wire fifo_pop = fifo_valid && !buffer_full_reg && tx_go;

    tx_fifo #(
        .WIDTH(`TX_FIFO_WIDTH),
        .DEPTH(`TX_FIFO_DEPTH),
        .AW(`TX_FIFO_AW)
    ) u_tx_fifo (
        .clk(clk),
        .arst_n(arst_n),
        .ce(ce),
        .flush(~tx_en),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .in_data(tx_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    reg [7:0] tbuf_reg;
    reg tbuf_mp_reg;
    reg [2:0] tx_state_reg;
    reg [7:0] tx_shift_reg;
    reg tx_mp_reg;
    reg [2:0] tx_idx_reg;
    reg tx_acc_reg;
    reg tx_line_reg;
    // a frame that ends on this tick hands over to the buffer without a gap
    wire tx_frame_end = baud_tick && ((tx_state_reg == S_STOP1 && !two_stops)
        || tx_state_reg == S_STOP2);
    wire tx_load = buffer_full_reg && ((tx_state_reg == S_IDLE && baud_tick) || tx_frame_end);

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tbuf_reg <= 8'h00;
            tbuf_mp_reg <= 1'b0;
            buffer_full_reg <= 1'b0;
            shift_busy_reg <= 1'b0;
            tx_state_reg <= S_IDLE;
            tx_shift_reg <= 8'h00;
            tx_mp_reg <= 1'b0;
            tx_idx_reg <= 3'd0;
            tx_acc_reg <= 1'b0;
            tx_line_reg <= 1'b1;
        end else if (ce) begin
            if (!tx_en) begin
                buffer_full_reg <= 1'b0;
                shift_busy_reg <= 1'b0;
                tx_state_reg <= S_IDLE;
                tx_line_reg <= 1'b1;
            end else begin
                if (fifo_pop) begin
                    tbuf_reg <= fifo_data;
                    tbuf_mp_reg <= mp_append_bit;
                    buffer_full_reg <= 1'b1;
                end else if (tx_load) begin
                    buffer_full_reg <= 1'b0;
                end
                if (tx_load) begin
                    tx_shift_reg <= tbuf_reg;
                    tx_mp_reg <= tbuf_mp_reg;
                    tx_idx_reg <= 3'd0;
                    tx_acc_reg <= 1'b0;
                    tx_line_reg <= 1'b0;
                    tx_state_reg <= S_START;
                    shift_busy_reg <= 1'b1;
                end else if (baud_tick) begin
                    case (tx_state_reg)
                        S_IDLE: begin
                            tx_line_reg <= 1'b1;
                        end
                        S_START, S_DATA: begin
                            if (tx_state_reg == S_START || tx_idx_reg != last_bit) begin
                                tx_line_reg <= tx_shift_reg[0];
                                tx_acc_reg <= tx_acc_reg ^ tx_shift_reg[0];
                                tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
                                if (tx_state_reg == S_DATA) begin
                                    tx_idx_reg <= tx_idx_reg + 3'd1;
                                end
                                tx_state_reg <= S_DATA;
                            end else begin
                                tx_state_reg <= next_field(S_DATA, multiproc_mode, par_mode);
                                if (multiproc_mode) begin
                                    tx_line_reg <= tx_mp_reg;
                                    tx_acc_reg <= tx_acc_reg ^ tx_mp_reg;
                                end else if (par_mode != `PARITY_NONE) begin
                                    tx_line_reg <= parity_bit(tx_acc_reg, par_mode);
                                end else begin
                                    tx_line_reg <= 1'b1;
                                end
                            end
                        end
                        S_MP: begin
                            tx_state_reg <= next_field(S_MP, multiproc_mode, par_mode);
                            tx_line_reg <= (par_mode != `PARITY_NONE)
                                ? parity_bit(tx_acc_reg, par_mode) : 1'b1;
                        end
                        S_PAR: begin
                            tx_state_reg <= S_STOP1;
                            tx_line_reg <= 1'b1;
                        end
                        S_STOP1: begin
                            tx_state_reg <= two_stops ? S_STOP2 : S_IDLE;
                            if (!two_stops) begin
                                shift_busy_reg <= 1'b0;
                            end
                        end
                        S_STOP2: begin
                            tx_state_reg <= S_IDLE;
                            shift_busy_reg <= 1'b0;
                        end
                        default: begin
                            tx_state_reg <= S_IDLE;
                        end
                    endcase
                end
            end
        end
    end

    assign serial_out_pin = power_on ? tx_line_reg : 1'b0;

    // ==========================================================
    // receiver
    reg [2:0] rx_state_reg;
    reg [7:0] rx_cnt_reg;
    reg [7:0] rx_shift_reg;
    reg [2:0] rx_idx_reg;
    reg rx_acc_reg;
    reg rx_mp_reg;
    reg rx_perr_reg;
    reg [7:0] rbuf_reg;
    reg rbuf_full_reg;
    reg rx_done_irq_reg;
    reg rx_err_irq_reg;
    // first sample lands mid start bit, later ones one full bit apart
    wire rx_sample = src_tick && (rx_cnt_reg == 8'h00);
    wire rx_bit = serial_in_pin;
    wire frame_err = ~rx_bit;
    wire ovr_err = rbuf_full_reg && !rx_read;
    wire [3:0] new_status = {multiproc_mode & rx_mp_reg, rx_perr_reg, frame_err, ovr_err};
    wire any_err = rx_perr_reg | frame_err | ovr_err;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_state_reg <= S_IDLE;
            rx_cnt_reg <= 8'h00;
            rx_shift_reg <= 8'h00;
            rx_idx_reg <= 3'd0;
            rx_acc_reg <= 1'b0;
            rx_mp_reg <= 1'b0;
            rx_perr_reg <= 1'b0;
            rbuf_reg <= 8'h00;
            rbuf_full_reg <= 1'b0;
            rx_status_reg <= RX_STATUS_RST[3:0];
            rx_done_irq_reg <= 1'b0;
            rx_err_irq_reg <= 1'b0;
        end else if (ce) begin
            rx_done_irq_reg <= 1'b0;
            rx_err_irq_reg <= 1'b0;
            if (!power_on) begin
                rx_status_reg <= 4'h0;
                rbuf_full_reg <= 1'b0;
            end else if (rx_read) begin
                rx_status_reg <= 4'h0;
                rbuf_full_reg <= 1'b0;
            end
            if (!rx_en) begin
                rx_state_reg <= S_IDLE;
            end else if (rx_state_reg == S_IDLE) begin
                if (rx_go && !rx_bit) begin
                    rx_state_reg <= S_START;
                    rx_cnt_reg <= {1'b0, k_eff[7:1]};
                    rx_idx_reg <= 3'd0;
                    rx_acc_reg <= 1'b0;
                    rx_mp_reg <= 1'b0;
                    rx_perr_reg <= 1'b0;
                end
            end else if (src_tick && !rx_sample) begin
                rx_cnt_reg <= rx_cnt_reg - 8'h01;
            end else if (rx_sample) begin
                rx_cnt_reg <= k_eff - 8'h01;
                case (rx_state_reg)
                    S_START: begin
                        rx_state_reg <= rx_bit ? S_IDLE : S_DATA;
                    end
                    S_DATA: begin
                        rx_shift_reg <= {rx_bit, rx_shift_reg[7:1]};
                        rx_acc_reg <= rx_acc_reg ^ rx_bit;
                        rx_idx_reg <= rx_idx_reg + 3'd1;
                        if (rx_idx_reg == last_bit) begin
                            rx_state_reg <= next_field(S_DATA, multiproc_mode, par_mode);
                        end
                    end
                    S_MP: begin
                        rx_mp_reg <= rx_bit;
                        rx_acc_reg <= rx_acc_reg ^ rx_bit;
                        rx_state_reg <= next_field(S_MP, multiproc_mode, par_mode);
                    end
                    S_PAR: begin
                        // zero parity is received but never judged
                        rx_perr_reg <= par_mode[1] & ~(rx_acc_reg ^ rx_bit ^ par_mode[0]);
                        rx_state_reg <= S_STOP1;
                    end
                    S_STOP1: begin
                        // only one stop bit is checked whatever the transmit setting
                        rx_state_reg <= S_IDLE;
                        rx_status_reg <= new_status;
                        if (!ovr_err) begin
                            rbuf_reg <= char8 ? rx_shift_reg : {1'b0, rx_shift_reg[7:1]};
                            rbuf_full_reg <= 1'b1;
                        end
                        rx_done_irq_reg <= ~(any_err & err_route);
                        rx_err_irq_reg <= any_err & err_route;
                    end
                    default: begin
                        rx_state_reg <= S_IDLE;
                    end
                endcase
            end
        end
    end

    assign rx_data = rbuf_reg;
    assign rx_data_valid = rbuf_full_reg;
    assign rx_complete_irq = rx_done_irq_reg;
    assign rx_error_irq = rx_err_irq_reg;

endmodule // serial_channel

`default_nettype wire

// ---- rtl/serial_channel_defines.vh ----
// constants for the multi-processor serial channel: map, fields, reset values, timing
`ifndef SERIAL_CHANNEL_DEFINES_VH
`define SERIAL_CHANNEL_DEFINES_VH

// ==========================================================
// register addresses
`define ADDR_SERIAL_MODE_CONTROL 16'hff90
`define ADDR_BAUD_DIVISOR 16'hff93
`define ADDR_TRANSMIT_STATUS 16'hff95
`define ADDR_RECEIVE_ERROR_STATUS 16'hffa1

// ==========================================================
// reset values
`define RST_SERIAL_MODE_CONTROL 8'h00
`define RST_BAUD_DIVISOR 8'h00
`define RST_TRANSMIT_STATUS 8'h00
`define RST_RECEIVE_ERROR_STATUS 8'h00

// ==========================================================
// serial_mode_control fields
`define BIT_CLOCK_POWER_ENABLE 7
`define BIT_TRANSMIT_ENABLE 6
`define BIT_RECEIVE_ENABLE 5
`define BIT_PARITY_SELECT_HIGH 4
`define BIT_PARITY_SELECT_LOW 3
`define BIT_CHAR_LENGTH_SELECT 2
`define BIT_STOP_BIT_COUNT_SELECT 1
`define BIT_ERROR_IRQ_ROUTING 0

// parity field encodings
`define PARITY_NONE 2'h0
`define PARITY_ZERO 2'h1
`define PARITY_ODD 2'h2
`define PARITY_EVEN 2'h3

// ==========================================================
// receive_error_status and transmit_status fields
`define BIT_ID_RECEIVED_FLAG 3
`define BIT_PARITY_ERROR_FLAG 2
`define BIT_FRAMING_ERROR_FLAG 1
`define BIT_OVERRUN_ERROR_FLAG 0
`define BIT_BUFFER_FULL_FLAG 1
`define BIT_SHIFT_BUSY_FLAG 0

// ==========================================================
// timing
`define SETTLE_TICKS 2'h2
`define MIN_DIVISOR 8'h08

// ==========================================================
// transmit buffer fifo shape
`define TX_FIFO_WIDTH 8
`define TX_FIFO_DEPTH 32
`define TX_FIFO_AW 5

`endif

// ---- rtl/tx_fifo.v ----
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module tx_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire clk,
    input wire arst_n,
    input wire ce,
    input wire flush,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);

    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] count_reg;
    wire push;
    wire pop;

    assign in_ready = ({{(31-AW){1'b0}}, count_reg} != DEPTH);
    assign out_valid = (count_reg != {(AW+1){1'b0}});
    assign out_data = mem_reg[rd_ptr_reg];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // ==========================================================
    // storage
    always @(posedge clk) begin
        if (ce && push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    // ==========================================================
    // pointers
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end else if (ce) begin
            if (flush) begin
                wr_ptr_reg <= {AW{1'b0}};
                rd_ptr_reg <= {AW{1'b0}};
                count_reg <= {(AW+1){1'b0}};
            end else begin
                if (push) begin
                    wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
                end
                if (pop) begin
                    rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
                end
                if (push && !pop) begin
                    count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
                end else if (pop && !push) begin
                    count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
                end
            end
        end
    end

endmodule // tx_fifo

`default_nettype wire

// ---- dv/serial_channel_properties.sv ----
// port-level assertions for the serial channel
`timescale 1ns/1ps
`default_nettype none
module serial_channel_checker (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [15:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [7:0] bus_wdata,
    input wire logic [7:0] bus_rdata,
    input wire logic tx_ready,
    input wire logic serial_out_pin,
    input wire logic rx_complete_irq,
    input wire logic rx_error_irq
);
    // ==========
    // mode shadow rebuilt from bus writes; assumes ce stays high
    logic [7:0] mode_reg;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) mode_reg <= 8'h00;
        else if (bus_wr && bus_addr == 16'hff90) mode_reg <= bus_wdata;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // ==========
    // properties
    property p_pwr_low; !mode_reg[7] |-> !serial_out_pin; endproperty
    a_pwr_low: assert property (p_pwr_low) else $error("line not low with power off");
    property p_idle_high; mode_reg[7] && $past(mode_reg[7]) && !mode_reg[6] && !$past(mode_reg[6])
        |-> serial_out_pin; endproperty
    a_idle_high: assert property (p_idle_high) else $error("line not idle high");
    property p_tx_flush; !mode_reg[6] && !$past(mode_reg[6]) |-> tx_ready; endproperty
    a_tx_flush: assert property (p_tx_flush) else $error("fifo not flushed");
    property p_rx_off; !mode_reg[5] && !$past(mode_reg[5]) |-> !(rx_complete_irq || rx_error_irq);
    endproperty
    a_rx_off: assert property (p_rx_off) else $error("irq with receiver off");
    property p_rs_hi; bus_rd && bus_addr == 16'hffa1 |=> bus_rdata[7:4] == 4'h0; endproperty
    a_rs_hi: assert property (p_rs_hi) else $error("receive status upper bits set");
    property p_ts_hi; bus_rd && bus_addr == 16'hff95 |=> bus_rdata[7:2] == 6'h00; endproperty
    a_ts_hi: assert property (p_ts_hi) else $error("transmit status upper bits set");
    property p_mode_rb; bus_rd && bus_addr == 16'hff90 |=> bus_rdata == $past(mode_reg); endproperty
    a_mode_rb: assert property (p_mode_rb) else $error("mode readback wrong");
    property p_cmp_pulse; rx_complete_irq |=> !rx_complete_irq; endproperty
    a_cmp_pulse: assert property (p_cmp_pulse) else $error("complete irq too long");
    property p_route; !mode_reg[0] && !$past(mode_reg[0]) |-> !rx_error_irq; endproperty
    a_route: assert property (p_route) else $error("error irq with route 0");
endmodule // serial_channel_checker
bind serial_channel serial_channel_checker chk (.clk(clk), .arst_n(arst_n), .bus_addr(bus_addr),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .tx_ready(tx_ready), .serial_out_pin(serial_out_pin), .rx_complete_irq(rx_complete_irq),
    .rx_error_irq(rx_error_irq));
`default_nettype wire

// ---- dv/far_sender.sv ----
// far-side processor transmitting frames onto the channel input
`timescale 1ns/1ps
`default_nettype none
module far_sender #(parameter int BIT_CYC = 16) (
    input wire logic clk,
    output logic line
);
    initial line = 1'b1;
    // caller builds start, data, parity and stop; line idles high after
    task automatic send(input logic [11:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            line = bits[i];
            repeat (BIT_CYC) @(negedge clk);
        end
        line = 1'b1;
    endtask
endmodule // far_sender
`default_nettype wire

// ---- dv/tb_top.sv ----
// self-checking bench for the serial channel
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 1'b0, arst_n = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0, tx_valid = 1'b0;
    logic rx_read = 1'b0, serial_in_pin, serial_out_pin, tx_ready, rx_data_valid, c_irq, e_irq;
    logic [15:0] bus_addr = 16'h0000;
    logic [7:0] bus_wdata = 8'h00, tx_data = 8'h00, bus_rdata, rx_data, got;
    logic [2:0] prescale_select = 3'h1;
    logic multiproc_mode = 1'b0;
    int n_cmp = 0, n_erq = 0;
    int failures = 0, n_tests = 0, n;
    initial forever #12.5 clk = ~clk;
    // interrupt pulses tallied so the bench sees every one of them
    always @(posedge clk) begin
        n_cmp += (c_irq === 1'b1);
        n_erq += (e_irq === 1'b1);
    end
    serial_channel dut (.clk(clk), .arst_n(arst_n), .ce(1'b1), .bus_addr(bus_addr),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .prescale_select(prescale_select), .ext_clk_in(1'b0), .multiproc_mode(multiproc_mode),
        .mp_append_bit(1'b0), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .rx_data(rx_data), .rx_data_valid(rx_data_valid), .rx_read(rx_read),
        .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
        .rx_complete_irq(c_irq), .rx_error_irq(e_irq));
    far_sender #(.BIT_CYC(16)) far (.clk(clk), .line(serial_in_pin));
    // ==========
    // shared tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("checks=%0d mismatches=%0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // one bus cycle; a read compares against d
    task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
        bus_addr = a;
        bus_wdata = d;
        bus_wr = w;
        bus_rd = !w;
        @(negedge clk);
        {bus_wr, bus_rd} = 2'b00;
        if (!w) check(bus_rdata, d);
        @(negedge clk);
    endtask
    task automatic pulse_read;
        rx_read = 1'b1;
        @(negedge clk);
        rx_read = 1'b0;
    endtask
    // ==========
    // scenarios
    task automatic t_reset;
        acc(0, 16'hff90, 8'h00);
        acc(0, 16'hff93, 8'h00);
        acc(0, 16'hff95, 8'h00);
        acc(0, 16'hffa1, 8'h00);
        acc(0, 16'hff91, 8'h00);
        check({7'h0, serial_out_pin}, 8'h00);
        acc(1, 16'hff90, 8'h80);
        check({7'h0, serial_out_pin}, 8'h01);
    endtask
    task automatic t_tx;
        acc(1, 16'hff93, 8'h08);
        acc(1, 16'hff90, 8'hc4);
        repeat (8) @(negedge clk);
        {tx_data, tx_valid} = {8'h4b, 1'b1};
        @(negedge clk);
        tx_valid = 1'b0;
        for (n = 0; n < 400 && serial_out_pin !== 1'b0; n++) @(negedge clk);
        if (n == 400) begin
            failures++;
            close_out;
        end
        acc(0, 16'hff95, 8'h01);
        repeat (6) @(negedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (16) @(negedge clk);
            got[i] = serial_out_pin;
        end
        check(got, 8'h4b);
        repeat (16) @(negedge clk);
        check({7'h0, serial_out_pin}, 8'h01);
        repeat (40) @(negedge clk);
        acc(0, 16'hff95, 8'h00);
    endtask
    // slow baud keeps one word parked in the buffer while the fifo fills
    task automatic t_fill;
        acc(1, 16'hff90, 8'h00);
        prescale_select = 3'h7;
        acc(1, 16'hff93, 8'hff);
        acc(1, 16'hff90, 8'hc4);
        repeat (300) @(negedge clk);
        tx_valid = 1'b1;
        for (n = 0; n < 40 && tx_ready === 1'b1; n++) @(negedge clk);
        tx_valid = 1'b0;
        check(n[7:0], 8'h21);
        acc(0, 16'hff95, 8'h02);
        acc(1, 16'hff90, 8'h84);
        acc(0, 16'hff95, 8'h00);
        check({7'h0, tx_ready}, 8'h01);
        acc(1, 16'hff90, 8'h00);
        prescale_select = 3'h1;
        acc(1, 16'hff93, 8'h08);
    endtask
    task automatic rx_mode(input logic [7:0] m);
        acc(1, 16'hff90, 8'h80);
        acc(1, 16'hff90, m);
        repeat (8) @(negedge clk);
    endtask
    task automatic t_rx;
        rx_mode(8'ha4);
        far.send({1'b1, 8'ha5, 1'b0}, 10);
        check(rx_data, 8'ha5);
        check({7'h0, rx_data_valid}, 8'h01);
        acc(0, 16'hffa1, 8'h00);
        far.send({1'b1, 8'h3c, 1'b0}, 10);
        acc(0, 16'hffa1, 8'h01);
        check(rx_data, 8'ha5);
        pulse_read;
        acc(0, 16'hffa1, 8'h00);
        check({7'h0, rx_data_valid}, 8'h00);
        rx_mode(8'ha5);
        far.send({1'b0, 8'h11, 1'b0}, 10);
        acc(0, 16'hffa1, 8'h02);
        check(n_erq[7:0], 8'h01);
        pulse_read;
        rx_mode(8'hbc);
        far.send({2'b10, 8'h01, 1'b0}, 11);
        acc(0, 16'hffa1, 8'h04);
        pulse_read;
        rx_mode(8'hac);
        far.send({2'b11, 8'h01, 1'b0}, 11);
        acc(0, 16'hffa1, 8'h00);
        far.send({2'b10, 8'h02, 1'b0}, 11);
        acc(0, 16'hffa1, 8'h01);
        acc(1, 16'hff90, 8'h00);
        acc(0, 16'hffa1, 8'h00);
        // id frame: 7 data bits, appended bit 1, odd parity
        multiproc_mode = 1'b1;
        rx_mode(8'hb0);
        far.send({3'b101, 7'h55, 1'b0}, 11);
        acc(0, 16'hffa1, 8'h08);
        check(rx_data, 8'h55);
        check(n_cmp[7:0], 8'h06);
    endtask
    initial begin
        repeat (6) @(negedge clk);
        arst_n = 1'b1;
        t_reset;
        t_tx;
        t_fill;
        t_rx;
        close_out;
    end
endmodule // tb_top
`default_nettype wire
